// ===== hdl/stop_clock_pkg.sv
// Package: constants and types for the stop-clock throttle and C2 control block
package stop_clock_pkg;

	// ****************************************************************
	// Register map inside the power-management I/O block
	// ****************************************************************
	localparam int          IO_ADDR_W        = 8;
	localparam logic [7:0]  LEVEL2_TRIG_OFS  = 8'h14;  // Level-2 entry trigger offset
	localparam int          TRIG_DATA_W      = 8;
	localparam logic [7:0]  LEVEL2_TRIG_RST  = 8'h00;  // Read value, all bits zero

	// ****************************************************************
	// Throttle window timing, in PCI clocks
	// ****************************************************************
	localparam int          DUTY_W           = 3;
	localparam int          WINDOW_CLKS      = 1024;
	localparam int          WIN_CNT_W        = $clog2(WINDOW_CLKS);
	localparam int          LEN_W            = WIN_CNT_W + 1;
	localparam logic [10:0] DUTY_STEP_CLKS   = 11'h080;  // 128 clocks per duty step
	localparam logic [10:0] DUTY_RSVD_CLKS   = 11'h200;  // Reserved code acts as 512
	localparam logic [2:0]  DUTY_RST         = 3'h0;
	localparam logic [3:0]  DUTY_STEPS       = 4'h8;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_C0 = 2'b01,
		ST_C2 = 2'b10
	} cstate_type;

	typedef struct packed {
		logic                 rd;    // One-cycle read strobe
		logic                 wr;    // One-cycle write strobe
		logic [IO_ADDR_W-1:0] addr;  // Offset from power_io_base
	} io_req_type;

endpackage

// ===== hdl/stop_clock_throttle_c2.sv
// Module: stop-clock throttling and level-2 sleep entry on the PCI clock
module stop_clock_throttle_c2 #(
	parameter int WINDOW = stop_clock_pkg::WINDOW_CLKS
) (
	input  wire logic                                   core_clk,
	input  wire logic                                   sys_rst,
	input  wire stop_clock_pkg::io_req_type             ioReq,
	input  wire logic                                   throttleEnable,
	input  wire logic [stop_clock_pkg::DUTY_W-1:0]      throttleDuty,
	input  wire logic                                   breakEvent,
	output logic [stop_clock_pkg::TRIG_DATA_W-1:0]      readData,
	output logic                                        readValid,
	output logic                                        inC2,
	output logic                                        stop_clock_n
);
	import stop_clock_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Asserted length in clocks for a duty code
	function automatic logic [LEN_W-1:0] assertLen(input logic [DUTY_W-1:0] code);
		logic [LEN_W-1:0] steps;
		steps = LEN_W'(DUTY_STEPS) - LEN_W'(code);
		if (code == DUTY_RST)
			assertLen = DUTY_RSVD_CLKS;
		else
			assertLen = LEN_W'(steps * DUTY_STEP_CLKS);
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	cstate_type            state_r;
	cstate_type            state_nxt;
	logic [WIN_CNT_W-1:0]  winCnt_r;
	logic [WIN_CNT_W-1:0]  winCnt_nxt;
	logic                  stopN_r;
	logic                  stopN_nxt;
	logic                  rdValid_r;
	logic [TRIG_DATA_W-1:0] rdData_r;
	logic                  inC2_r;

	// ****************************************************************
	// Decode
	// ****************************************************************

	// Level-2 trigger read hit; writes are never decoded so they cannot act
	wire trigRead   = ioReq.rd && (ioReq.addr == LEVEL2_TRIG_OFS);
	wire throttleOn = throttleEnable && (state_r == ST_C0);
	wire [LEN_W-1:0] curLen  = assertLen(throttleDuty);
	wire inAssertPart        = {1'b0, winCnt_r} < curLen;
	wire lastCount           = winCnt_r == WIN_CNT_W'(WINDOW - 1);

	// Window counter wraps every window period
	assign winCnt_nxt = lastCount ? '0 : winCnt_r + 1'b1;

	// C2 entry on trigger read wins over a break in the same cycle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_C0: begin
				if (trigRead)
					state_nxt = ST_C2;
			end
			ST_C2: begin
				if (breakEvent && !trigRead)
					state_nxt = ST_C0;
			end
			default: state_nxt = ST_C0;
		endcase
	end

	// C2 holds stop-clock low regardless of duty; otherwise duty shaping
	assign stopN_nxt = !((state_r == ST_C2) || (throttleOn && inAssertPart));

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Power state and throttle window
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r  <= ST_C0;
			winCnt_r <= '0;
			stopN_r  <= 1'b1;
			inC2_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			winCnt_r <= winCnt_nxt;
			stopN_r  <= stopN_nxt;
			inC2_r   <= (state_nxt == ST_C2);
		end
	end

	// Read answer: every register read here returns zero
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdValid_r <= 1'b0;
			rdData_r  <= LEVEL2_TRIG_RST;
		end else begin
			rdValid_r <= ioReq.rd;
			rdData_r  <= LEVEL2_TRIG_RST;
		end
	end

	assign readData     = rdData_r;
	assign readValid    = rdValid_r;
	assign inC2         = inC2_r;
	assign stop_clock_n = stopN_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// All checks run on the PCI clock and rest while reset is applied
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	trig_entry_a: assert property (
		trigRead |=> (state_r == ST_C2) ##1 !stopN_r)
		else $error("Trigger read did not enter C2");

	read_zero_a: assert property (
		rdValid_r |-> (rdData_r == 8'h00))
		else $error("Trigger read returned nonzero data");

	write_none_a: assert property (
		(ioReq.wr && !ioReq.rd && !breakEvent) |=> (state_r == $past(state_r)))
		else $error("Write changed power state");

	c2_hold_a: assert property (
		(state_r == ST_C2) |=> !stopN_r)
		else $error("Stop-clock released while in C2");

	c2_steady_a: assert property (
		((state_r == ST_C2) && !breakEvent) [*3] |=> !stopN_r [*2])
		else $error("Throttling acted during C2");

	break_exit_a: assert property (
		((state_r == ST_C2) && breakEvent && !trigRead) |=> (state_r == ST_C0))
		else $error("Break event did not leave C2");

	window_wrap_a: assert property (
		(winCnt_r == 10'h3ff) |=> (winCnt_r == 10'h000))
		else $error("Throttle window did not wrap at 1024");

	duty_len_a: assert property (
		($rose(stopN_r) && $past(throttleEnable) && $past(state_r == ST_C0)
			&& $past(throttleEnable, 2) && $past(state_r == ST_C0, 2)
			&& $past(throttleDuty, 2) == $past(throttleDuty))
		|-> ({1'b0, $past(winCnt_r)} == assertLen($past(throttleDuty))))
		else $error("Asserted span differs from duty code");

	rsvd_half_a: assert property (
		((winCnt_r == 10'h200) && throttleEnable && (throttleDuty == 3'h0)
			&& (state_r == ST_C0)) |=> stopN_r)
		else $error("Reserved duty code not 512 clocks");

	no_throttle_a: assert property (
		(!throttleEnable && (state_r == ST_C0)) |=> stopN_r)
		else $error("Throttled while disabled in C0");

	rsvd_low_a: assert property (
		((winCnt_r == 10'h1ff) && throttleEnable && (throttleDuty == 3'h0)
			&& (state_r == ST_C0)) |=> !stopN_r)
		else $error("Reserved duty code released early");

	win_start_a: assert property (
		(throttleOn && (winCnt_r == 10'h000)) |=> !stopN_r)
		else $error("Window start did not assert stop-clock");

	short_span_a: assert property (
		(throttleOn && (winCnt_r == 10'h07f)) |=> !stopN_r)
		else $error("Shortest asserted span not honoured");

	c0_stay_a: assert property (
		((state_r == ST_C0) && !trigRead) |=> (state_r == ST_C0))
		else $error("Left C0 without a trigger read");

	trig_wins_a: assert property (
		(trigRead && breakEvent) |=> (state_r == ST_C2))
		else $error("Break beat a trigger read in the same cycle");

	read_answer_a: assert property (
		ioReq.rd |=> (readValid && (readData == LEVEL2_TRIG_RST)))
		else $error("Read not answered with zero data");

	valid_once_a: assert property (
		!ioReq.rd |=> !readValid)
		else $error("Read answer without a read strobe");

	c2_flag_a: assert property (
		inC2 == (state_r == ST_C2))
		else $error("C2 flag disagrees with power state");

	exit_release_a: assert property (
		((state_r == ST_C2) && breakEvent && !trigRead) ##1 !throttleEnable |=> stopN_r)
		else $error("Stop-clock held after C2 exit while disabled");

	// ****************************************************************
	// Cover points
	// ****************************************************************

	// Main scenarios: entry, exit, duty shaping and the entry-over-break race
	c2_entry_c: cover property (trigRead ##1 (state_r == ST_C2));
	c2_break_c: cover property ((state_r == ST_C2) ##1 breakEvent ##1 (state_r == ST_C0));
	throttle_c: cover property (throttleOn && $fell(stopN_r));
	duty7_c:    cover property (throttleOn && (throttleDuty == 3'h7) && $rose(stopN_r));
	trig_break_c: cover property (trigRead && breakEvent && (state_r == ST_C2));

endmodule

// ===== sim/cpu_stop_model.sv
// Host processor model that counts the cycles its clock is held stopped
module cpu_stop_model (
	input  wire logic        core_clk,
	input  wire logic        stop_clock_n,
	input  wire logic        clearCount,
	output logic [15:0]      lowCount
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Stopped-cycle counter
	// ****************************************************************
	// Counts every rising edge seen with stop-clock asserted, cleared on request
	always_ff @(posedge core_clk) begin
		if (clearCount) begin
			lowCount <= 16'h0000;
		end else if (stop_clock_n === 1'b0) begin
			lowCount <= lowCount + 16'h0001;
		end
	end
endmodule

// ===== sim/testbench.sv
// Testbench for the stop-clock throttle and level-2 sleep block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import stop_clock_pkg::*;
	logic                 core_clk;
	logic                 sys_rst;
	io_req_type           ioReq;
	logic                 throttleEnable;
	logic [DUTY_W-1:0]    throttleDuty;
	logic                 breakEvent;
	logic [7:0]           readData;
	logic                 readValid;
	logic                 inC2;
	logic                 stop_clock_n;
	logic                 clearCount;
	logic [15:0]          lowCount;
	int                   mismatches;
	int                   checkCount;
	// One row per duty code: the code driven and the stopped clocks per window
	typedef struct packed {
		logic [DUTY_W-1:0] duty;
		logic [15:0]       lowClks;
	} duty_row_type;
	duty_row_type         dutyRows [8] = '{
		'{3'h0, 16'h0200}, '{3'h1, 16'h0380}, '{3'h2, 16'h0300}, '{3'h3, 16'h0280},
		'{3'h4, 16'h0200}, '{3'h5, 16'h0180}, '{3'h6, 16'h0100}, '{3'h7, 16'h0080}};
	stop_clock_throttle_c2 stop_clock_throttle_c2_inst (.core_clk(core_clk),
		.sys_rst(sys_rst), .ioReq(ioReq), .throttleEnable(throttleEnable),
		.throttleDuty(throttleDuty), .breakEvent(breakEvent), .readData(readData),
		.readValid(readValid), .inC2(inC2), .stop_clock_n(stop_clock_n));
	cpu_stop_model cpu_stop_model_inst (.core_clk(core_clk), .stop_clock_n(stop_clock_n),
		.clearCount(clearCount), .lowCount(lowCount));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Counts stopped cycles over one full window
	task automatic measure(input logic [15:0] exp);
		clearCount = 1'b1;
		@(negedge core_clk);
		clearCount = 1'b0;
		repeat (WINDOW_CLKS) @(negedge core_clk);
		check("stopped clocks", exp, lowCount);
	endtask
	// One strobe cycle; answer looked at in the following cycle
	task automatic access(input logic rd, input logic [7:0] addr);
		ioReq = '{rd, ~rd, addr};
		@(negedge core_clk);
		ioReq = '0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#500us;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		sys_rst = 1'b1;
		ioReq = '0;
		throttleEnable = 1'b1;
		throttleDuty = DUTY_RST;
		breakEvent = 1'b0;
		clearCount = 1'b0;
		repeat (2) @(negedge core_clk);
		check("reset stop", 16'h1, 16'(stop_clock_n));
		check("reset c2", 16'h0, 16'(inC2));
		sys_rst = 1'b0;
		// Each duty code shapes one window
		foreach (dutyRows[r]) begin
			throttleDuty = dutyRows[r].duty;
			repeat (WINDOW_CLKS) @(negedge core_clk);
			measure(dutyRows[r].lowClks);
		end
		throttleEnable = 1'b0;
		measure(16'h0000);
		access(1'b0, LEVEL2_TRIG_OFS);
		check("write c2", 16'h0, 16'(inC2));
		check("write answer", 16'h0, 16'(readValid));
		@(negedge core_clk);
		access(1'b1, 8'h20);
		check("other read c2", 16'h0, 16'(inC2));
		check("other read valid", 16'h1, 16'(readValid));
		@(negedge core_clk);
		throttleEnable = 1'b1;
		access(1'b1, LEVEL2_TRIG_OFS);
		check("valid", 16'h1, 16'(readValid));
		check("data", 16'(LEVEL2_TRIG_RST), 16'(readData));
		check("enter c2", 16'h1, 16'(inC2));
		measure(16'h0400);
		breakEvent = 1'b1;
		@(negedge core_clk);
		breakEvent = 1'b0;
		check("leave c2", 16'h0, 16'(inC2));
		repeat (WINDOW_CLKS) @(negedge core_clk);
		measure(16'h0080);
		// Trigger read and break in one cycle: entry wins
		access(1'b1, LEVEL2_TRIG_OFS);
		check("re-enter c2", 16'h1, 16'(inC2));
		@(negedge core_clk);
		breakEvent = 1'b1;
		access(1'b1, LEVEL2_TRIG_OFS);
		breakEvent = 1'b0;
		check("trig over break", 16'h1, 16'(inC2));
		// Leaving C2 with throttling off releases stop-clock one cycle later
		throttleEnable = 1'b0;
		@(negedge core_clk);
		breakEvent = 1'b1;
		@(negedge core_clk);
		breakEvent = 1'b0;
		check("exit c2", 16'h0, 16'(inC2));
		check("held one more", 16'h0, 16'(stop_clock_n));
		@(negedge core_clk);
		check("released", 16'h1, 16'(stop_clock_n));
		// Reset in mid-run while in C2, then a fresh window at code 111
		throttleEnable = 1'b1;
		access(1'b1, LEVEL2_TRIG_OFS);
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		check("mid reset stop", 16'h1, 16'(stop_clock_n));
		check("mid reset c2", 16'h0, 16'(inC2));
		check("mid reset valid", 16'h0, 16'(readValid));
		sys_rst = 1'b0;
		repeat (128) @(negedge core_clk);
		check("first span low", 16'h0, 16'(stop_clock_n));
		@(negedge core_clk);
		check("first span end", 16'h1, 16'(stop_clock_n));
		tally_and_finish();
	end
endmodule
